// file: inc/efh_cfg.svh
// constants of the elastic fifo host: register map, fields, timing
// assumes a 25 MHz pclk and a 32-bit apb slave port
`ifndef EFH_CFG_SVH
`define EFH_CFG_SVH

// ****************************************************
// geometry of the attached store
// ****************************************************
`define EFH_DEPTH 16
`define EFH_WORD_W 4

// ****************************************************
// register byte offsets
// ****************************************************
`define EFH_ADDR_W 12
`define EFH_OFF_CTRL 12'h000
`define EFH_OFF_PUSH 12'h004
`define EFH_OFF_RDATA 12'h008
`define EFH_OFF_STATUS 12'h00C

// ****************************************************
// field positions
// ****************************************************
`define EFH_CTRL_CLEAR 0
`define EFH_CTRL_POP 1
`define EFH_CTRL_OE 2
`define EFH_RD_NEW 8
`define EFH_ST_SPACE 0
`define EFH_ST_VALID 1
`define EFH_ST_BUSY 2
`define EFH_ST_READY 3
`define EFH_ST_CNT_LSB 8

// ****************************************************
// reset values and timing
// ****************************************************
`define EFH_RST_WORD 4'h0
`define EFH_CLK_NS 40
`define EFH_MC_NS 100
`define EFH_STB_NS 80
`define EFH_MC_CYC ((`EFH_MC_NS + `EFH_CLK_NS - 1) / `EFH_CLK_NS)
`define EFH_STB_CYC ((`EFH_STB_NS + `EFH_CLK_NS - 1) / `EFH_CLK_NS)

`endif

// file: inc/efh_pkg.sv
// types shared by the elastic fifo host files
// assumes efh_cfg.svh is on the include path
`include "efh_cfg.svh"

package efh_pkg;

    // ****************************************************
    // controller states
    // ****************************************************
    typedef enum logic [2:0] {
        S_CLEAR = 3'b000,
        S_IDLE = 3'b001,
        S_PUSH_WAIT = 3'b010,
        S_PUSH_HI = 3'b011,
        S_PUSH_HOLD = 3'b100,
        S_POP_WAIT = 3'b101,
        S_POP_HI = 3'b110,
        S_POP_SETTLE = 3'b111
    } efh_state_e;

    // ****************************************************
    // pins toward and from the store
    // ****************************************************
    typedef struct packed {
        logic master_clear;
        logic push_strobe;
        logic pop_strobe;
        logic out_en_n;
        logic [`EFH_WORD_W-1:0] write_word;
    } efh_pins_out_s;

    typedef struct packed {
        logic input_space;
        logic output_valid_flag;
        logic [`EFH_WORD_W-1:0] read_word;
    } efh_pins_in_s;

endpackage

// file: logic/efh_pulse.sv
// fixed-width strobe generator used for every pin pulse of the host
// assumes start is only raised while the strobe is idle
`timescale 1ns/10ps

module efh_pulse #(
    parameter int WIDTH = 2
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic start, // begin a pulse
    output logic active, // strobe level, high for WIDTH cycles
    output logic done // last high cycle of the strobe
);
    localparam int CW = (WIDTH > 1) ? $clog2(WIDTH) : 1;

    logic active_q;
    logic [CW-1:0] cnt_q;

    assign active = active_q;
    assign done = active_q && (cnt_q == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
            cnt_q <= '0;
        end else if (!active_q && start) begin
            active_q <= 1'b1;
            cnt_q <= CW'(WIDTH - 1);
        end else if (active_q) begin
            active_q <= (cnt_q != '0);
            cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
        end
    end

endmodule // efh_pulse

// file: logic/efh_host.sv
// apb-controlled host that writes and reads an elastic 16x4 fifo store
// assumes the store's flags are synchronous to pclk and pready is unused
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "efh_cfg.svh"

module efh_host #(
    parameter int DEPTH = `EFH_DEPTH,
    parameter int MC_CYC = `EFH_MC_CYC,
    parameter int STB_CYC = `EFH_STB_CYC
) (
    input wire logic pclk, // system clock, 25 MHz
    input wire logic presetn, // async reset, active low
    input wire logic [`EFH_ADDR_W-1:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready, always high
    output logic pslverr, // apb error: unmapped, refused or write to a read-only register
    output efh_pkg::efh_pins_out_s pin_o, // pins driven to the store
    input wire efh_pkg::efh_pins_in_s pin_i // pins read from the store
);
    localparam int CNT_W = $clog2(DEPTH + 1);

    // ****************************************************
    // state
    // ****************************************************
    efh_pkg::efh_state_e state_q, state_d;
    logic mc_go_q;
    logic ready_q;
    logic out_en_q;
    logic oe_n_q;
    logic rd_new_q;
    logic [CNT_W-1:0] cnt_q;
    logic [`EFH_WORD_W-1:0] wword_q;
    logic [`EFH_WORD_W-1:0] rword_q;
    logic [31:0] prdata_q;

    logic mc_active, mc_done;
    logic push_active, push_done;
    logic pop_active, pop_done;

    // ****************************************************
    // apb decode
    // ****************************************************
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr_acc = access && pwrite;
    wire rd_acc = access && !pwrite;
    wire sel_ctrl = (paddr == `EFH_OFF_CTRL);
    wire sel_push = (paddr == `EFH_OFF_PUSH);
    wire sel_rdata = (paddr == `EFH_OFF_RDATA);
    wire sel_status = (paddr == `EFH_OFF_STATUS);
    wire mapped = sel_ctrl || sel_push || sel_rdata || sel_status;
    wire idle = (state_q == efh_pkg::S_IDLE);
    wire want_clr = wr_acc && sel_ctrl && pwdata[`EFH_CTRL_CLEAR];
    wire want_pop = wr_acc && sel_ctrl && pwdata[`EFH_CTRL_POP]
        && !pwdata[`EFH_CTRL_CLEAR];
    wire want_push = wr_acc && sel_push;
    wire clr_cmd = want_clr && idle;
    // a pop is refused while nothing is stored so the host never waits
    // on a word that cannot arrive
    wire pop_cmd = want_pop && idle && ready_q && (cnt_q != '0);
    // the host keeps its own word count and refuses a push that would
    // overflow, whatever the flags show
    wire push_cmd = want_push && idle && ready_q
        && (cnt_q < CNT_W'(DEPTH));
    wire refused = (want_clr && !clr_cmd) || (want_pop && !pop_cmd)
        || (want_push && !push_cmd);
    wire ro_write = wr_acc && (sel_rdata || sel_status);

    assign pready = 1'b1;
    assign pslverr = access && (!mapped || refused || ro_write);
    assign prdata = prdata_q;

    wire [31:0] rd_mux =
        sel_ctrl ? {29'h0000_000, out_en_q, 2'b00} :
        sel_rdata ? {23'h00_0000, rd_new_q, 4'h0, rword_q} :
        sel_status ? {{(24 - CNT_W){1'b0}}, cnt_q, 4'h0, ready_q,
            !idle, pin_i.output_valid_flag, pin_i.input_space} :
        32'h0000_0000;

    // ****************************************************
    // sequencing
    // ****************************************************
    // the strobe is only raised on a free input stage
    wire push_start = (state_q == efh_pkg::S_PUSH_WAIT)
        && pin_i.input_space;
    wire pop_start = (state_q == efh_pkg::S_POP_WAIT)
        && pin_i.output_valid_flag;
    wire pop_state = (state_q == efh_pkg::S_POP_WAIT)
        || (state_q == efh_pkg::S_POP_HI);
    // outputs are enabled for every pop so the word can be sampled
    wire oe_n_d = !(out_en_q || pop_state);

    always_comb begin
        state_d = state_q;
        case (state_q)
            efh_pkg::S_CLEAR: begin
                if (mc_done) begin
                    state_d = efh_pkg::S_IDLE;
                end
            end
            efh_pkg::S_IDLE: begin
                if (clr_cmd) begin
                    state_d = efh_pkg::S_CLEAR;
                end else if (push_cmd) begin
                    state_d = efh_pkg::S_PUSH_WAIT;
                end else if (pop_cmd) begin
                    state_d = efh_pkg::S_POP_WAIT;
                end
            end
            efh_pkg::S_PUSH_WAIT: begin
                if (push_start) begin
                    state_d = efh_pkg::S_PUSH_HI;
                end
            end
            efh_pkg::S_PUSH_HI: begin
                // strobe is released after its fixed width, so a word
                // never waits in front with push held high
                if (push_done) begin
                    state_d = efh_pkg::S_PUSH_HOLD;
                end
            end
            efh_pkg::S_PUSH_HOLD: begin
                state_d = efh_pkg::S_IDLE;
            end
            efh_pkg::S_POP_WAIT: begin
                if (pop_start) begin
                    state_d = efh_pkg::S_POP_HI;
                end
            end
            efh_pkg::S_POP_HI: begin
                if (pop_done) begin
                    state_d = efh_pkg::S_POP_SETTLE;
                end
            end
            efh_pkg::S_POP_SETTLE: begin
                // pop is low here, before any further pop can start
                state_d = efh_pkg::S_IDLE;
            end
            default: begin
                state_d = efh_pkg::S_CLEAR;
            end
        endcase
    end

    // ****************************************************
    // registers
    // ****************************************************
    // mc_go_q resets high so the first action after reset is a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= efh_pkg::S_CLEAR;
            mc_go_q <= 1'b1;
            ready_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            mc_go_q <= clr_cmd;
            ready_q <= ready_q || mc_done;
            oe_n_q <= oe_n_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (mc_done) begin
            cnt_q <= '0;
        end else if (state_q == efh_pkg::S_PUSH_HOLD) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (state_q == efh_pkg::S_POP_SETTLE) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // write word is loaded at acceptance, a full cycle before the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wword_q <= `EFH_RST_WORD;
        end else if (push_cmd) begin
            wword_q <= pwdata[`EFH_WORD_W-1:0];
        end
    end

    // a new word sets rd_new even in the cycle software reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rword_q <= `EFH_RST_WORD;
            rd_new_q <= 1'b0;
        end else if (pop_done) begin
            rword_q <= pin_i.read_word;
            rd_new_q <= 1'b1;
        end else if (rd_acc && sel_rdata) begin
            rd_new_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_en_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (wr_acc && sel_ctrl) begin
                out_en_q <= pwdata[`EFH_CTRL_OE];
            end
            if (setup && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ****************************************************
    // strobe generators
    // ****************************************************
    efh_pulse #(.WIDTH(MC_CYC)) u_mc (
        .pclk(pclk),
        .presetn(presetn),
        .start(mc_go_q),
        .active(mc_active),
        .done(mc_done)
    );

    efh_pulse #(.WIDTH(STB_CYC)) u_push (
        .pclk(pclk),
        .presetn(presetn),
        .start(push_start),
        .active(push_active),
        .done(push_done)
    );

    efh_pulse #(.WIDTH(STB_CYC)) u_pop (
        .pclk(pclk),
        .presetn(presetn),
        .start(pop_start),
        .active(pop_active),
        .done(pop_done)
    );

    // one driver for the whole pin bundle, fields in declaration order
    assign pin_o = {mc_active, push_active, pop_active, oe_n_q, wword_q};

    // ****************************************************
    // checks
    // ****************************************************
    sequence push_pulse_s;
        pin_o.push_strobe [*2] ##1 !pin_o.push_strobe;
    endsequence

    chk_clear_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ready_q |-> !pin_o.push_strobe && !pin_o.pop_strobe)
        else $error("strobe before the first clear");

    chk_clear_width: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pin_o.master_clear) |-> pin_o.master_clear [*3]
            ##1 !pin_o.master_clear)
        else $error("master clear pulse has wrong width");

    chk_push_space: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pin_o.push_strobe) |-> $past(pin_i.input_space))
        else $error("push raised without input space");

    chk_push_data: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_o.push_strobe |-> $stable(pin_o.write_word))
        else $error("write word moved during push");

    chk_push_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pin_o.push_strobe) |-> push_pulse_s)
        else $error("push strobe not released in time");

    chk_no_overflow: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(pin_o.push_strobe) |-> cnt_q < CNT_W'(DEPTH))
        else $error("push beyond capacity");

    chk_pop_rest: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(pin_o.pop_strobe) |-> !pin_o.pop_strobe [*2])
        else $error("pop strobe not low between words");

endmodule // efh_host

// file: tb/efh_store_model.sv
// behavioural elastic 16x4 store that answers the host's pins
// assumes pclk from the bench; flags change just after a rising edge
`timescale 1ns/10ps

module efh_store_model #(
    parameter int LAT = 1
) (
    input wire logic pclk, // bench clock
    input wire efh_pkg::efh_pins_out_s pin_o, // pins from the host
    output efh_pkg::efh_pins_in_s pin_i // flags and word to the host
);
    // ************************************************
    // store state
    // ************************************************
    logic [3:0] q[$];
    logic [3:0] hold_q = 4'h0;
    logic [3:0] out_q = 4'h5;
    logic busy_q = 1'b0;
    logic rdy_q = 1'b0;
    logic pend_q = 1'b0;
    logic si_q = 1'b0;
    logic so_q = 1'b0;
    logic auto_q = 1'b0;
    int wait_c = 0;

    initial pin_i = '0;

    // a push held high is remembered so it loads once room appears
    always @(posedge pclk) begin
        if (pin_o.push_strobe && !si_q) pend_q = 1'b1;
        if (!pin_o.push_strobe) pend_q = 1'b0;
        if (pin_o.master_clear) begin
            q.delete();
            busy_q = 1'b0;
            rdy_q = 1'b0;
        end else begin
            // pop held high on an empty store arms an automatic pop
            auto_q = pin_o.pop_strobe
                && (auto_q || (!rdy_q && q.size() == 0));
            if (pend_q && !busy_q && q.size() < 16) begin
                hold_q = pin_o.write_word;
                busy_q = 1'b1;
                pend_q = 1'b0;
            end
            if (!pin_o.push_strobe && busy_q) begin
                q.push_back(hold_q);
                busy_q = 1'b0;
            end
            if (!pin_o.pop_strobe && so_q && rdy_q) begin
                void'(q.pop_front());
                rdy_q = 1'b0;
                wait_c = LAT;
            end
            if (!rdy_q && q.size() > 0) begin
                if (wait_c > 0) begin
                    wait_c--;
                end else begin
                    out_q = q[0];
                    rdy_q = 1'b1;
                end
            end else if (rdy_q && pin_o.pop_strobe && auto_q) begin
                void'(q.pop_front());
                rdy_q = 1'b0;
            end
        end
        si_q = pin_o.push_strobe;
        so_q = pin_o.pop_strobe;
        pin_i.input_space <= !busy_q && q.size() < 16;
        pin_i.output_valid_flag <= rdy_q;
        pin_i.read_word <= pin_o.out_en_n ? 4'hz : out_q;
    end
endmodule // efh_store_model

// file: tb/efh_host_tb.sv
// self-checking bench for the apb host of the elastic store
// assumes efh_store_model and the host design are compiled before it
`timescale 1ns/10ps
`include "efh_cfg.svh"

module efh_host_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    efh_pkg::efh_pins_out_s pin_o;
    efh_pkg::efh_pins_in_s pin_i;
    int error_cnt = 0;
    int compares = 0;
    int seed = 84;
    int cnt = 0;
    logic [3:0] exp_q[$];
    logic [31:0] rd;
    logic err;

    initial begin
        forever #20 pclk = ~pclk;
    end

    efh_host u_efh_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_o(pin_o), .pin_i(pin_i));

    efh_store_model #(.LAT(2)) u_efh_store_model (.pclk(pclk),
        .pin_o(pin_o), .pin_i(pin_i));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // entered just after a rising edge; leaves one idle edge behind
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(`EFH_OFF_STATUS, 1'b0, 32'h0000_0000);
            n++;
        end while (rd[3:2] !== 2'b10 && n < 60);
        if (rd[3:2] !== 2'b10) begin
            error_cnt++;
            $display("MISMATCH %0t host stayed busy", $time);
        end
    endtask

    task automatic status();
        apb(`EFH_OFF_STATUS, 1'b0, 32'h0000_0000);
        check(rd, {19'h0, 5'(cnt), 4'h0, 2'b10, 1'(cnt > 0), 1'(cnt < 16)},
              "status");
    endtask

    task automatic push(input logic [3:0] w);
        apb(`EFH_OFF_PUSH, 1'b1, {28'h000_0000, w});
        check(32'(err), 32'(cnt >= 16), "push refusal");
        if (cnt < 16) begin
            exp_q.push_back(w);
            cnt++;
        end
        wait_idle();
    endtask

    task automatic pop();
        logic [3:0] e;
        apb(`EFH_OFF_CTRL, 1'b1, 32'h0000_0002);
        check(32'(err), 32'(cnt == 0), "pop refusal");
        if (cnt > 0) begin
            wait_idle();
            e = exp_q.pop_front();
            cnt--;
            apb(`EFH_OFF_RDATA, 1'b0, 32'h0000_0000);
            check(rd, {23'h0, 1'b1, 4'h0, e}, "popped word");
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(`EFH_OFF_PUSH, 1'b1, 32'h0000_0005);
        check(32'(err), 32'h1, "push before clear ends");
        wait_idle();
        status();
        $display("test reset done");
        for (int i = 0; i < 17; i++) push(4'($random(seed)));
        status();
        for (int i = 0; i < 17; i++) pop();
        status();
        $display("test fill and drain done");
        for (int i = 0; i < 40; i++) begin
            if ($random(seed) & 1) push(4'($random(seed)));
            else pop();
        end
        status();
        $display("test mixed traffic done");
        repeat (3) push(4'($random(seed)));
        apb(`EFH_OFF_CTRL, 1'b1, 32'h0000_0001);
        wait_idle();
        exp_q.delete();
        cnt = 0;
        status();
        pop();
        push(4'hA);
        pop();
        $display("test clear done");
        apb(`EFH_OFF_CTRL, 1'b1, 32'h0000_0004);
        apb(`EFH_OFF_CTRL, 1'b0, 32'h0000_0000);
        check(32'(rd[2]), 32'h1, "enable bit");
        check(32'(pin_o.out_en_n), 32'h0, "enable pin");
        apb(`EFH_OFF_CTRL, 1'b1, 32'h0000_0000);
        apb(`EFH_OFF_CTRL, 1'b0, 32'h0000_0000);
        check(32'(rd[2]), 32'h0, "disable bit");
        check(32'(pin_o.out_en_n), 32'h1, "disable pin");
        apb(12'h010, 1'b0, 32'h0000_0000);
        check(32'(err), 32'h1, "unmapped");
        apb(`EFH_OFF_STATUS, 1'b1, 32'h0000_00FF);
        check(32'(err), 32'h1, "read-only write");
        $display("test registers done");
        complete_run();
    end

    initial begin
        #(40 * 30000);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end
endmodule // efh_host_tb
